//--- hdl/spi_diag_dev.sv
// sensor end of the diagnostic link: command decoder and register pointer
`timescale 1ns/1ps
module spi_diag_dev
    import spi_diag_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // link
    spi_diag_if.dev          link,
    // sensor side
    input  wire logic [9:0]  accel_sample,
    output logic             diag_prog_mode,
    output logic             entry_locked,
    output logic             reg_wr_pulse,
    output logic [7:0]       reg_wr_addr,
    output logic [7:0]       reg_wr_data
);

    // =====================================================================
    // state
    typedef struct packed {
        logic              sclk_a;
        logic              sclk_b;
        logic              sclk_c;
        logic              cs_a;
        logic              cs_b;
        logic              cs_c;
        logic              mosi_a;
        logic              mosi_b;
        mode_t             mode;
        logic              skip;
        logic [4:0]        cnt;
        logic [15:0]       rx;
        logic [15:0]       tx;
        logic [7:0]        ptr;
        logic [255:0][7:0] regs;
        logic              wr_pulse;
        logic [7:0]        wr_addr;
        logic [7:0]        wr_data;
    } dev_state_t;

    dev_state_t s_q;
    dev_state_t s_d;

    // =====================================================================
    // helpers

    // puts odd parity into the reply parity bit
    function automatic logic [15:0] odd_reply(input logic [15:0] w);
        logic [15:0] r;
        r              = w;
        r[RSP_PAR_POS] = 1'b0;
        r[RSP_PAR_POS] = ~(^r);
        return r;
    endfunction

    function automatic logic [15:0] hdr(input logic [4:0] h, input logic [1:0] lo,
                                        input logic [7:0] body);
        return odd_reply({h, 1'b0, lo, body});
    endfunction

    // =====================================================================
    // edges seen through the synchronisers
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic in_frame;
    logic rd_par_ok;
    logic wr_par_ok;
    logic [4:0] op;

    assign sclk_rise = s_q.sclk_b & ~s_q.sclk_c;
    assign sclk_fall = ~s_q.sclk_b & s_q.sclk_c;
    assign cs_fall   = ~s_q.cs_b & s_q.cs_c;
    assign cs_rise   = s_q.cs_b & ~s_q.cs_c;
    assign in_frame  = ~s_q.cs_b;
    assign op        = s_q.rx[OP_MSB:OP_LSB];
    assign rd_par_ok = ^s_q.rx[OP_MSB:PAR_RD_POS];
    assign wr_par_ok = ^s_q.rx;

    // =====================================================================
    // next state
    always_comb begin
        s_d          = s_q;
        s_d.wr_pulse = 1'b0;
        s_d.sclk_a   = link.sclk;
        s_d.sclk_b   = s_q.sclk_a;
        s_d.sclk_c   = s_q.sclk_b;
        s_d.cs_a     = link.cs_n;
        s_d.cs_b     = s_q.cs_a;
        s_d.cs_c     = s_q.cs_b;
        s_d.mosi_a   = link.mosi;
        s_d.mosi_b   = s_q.mosi_a;

        if (cs_fall) begin
            s_d.cnt = 5'h00;
        end
        // mode 0: take data on the rising edge, move on at the falling one
        if (in_frame && sclk_rise) begin
            s_d.rx = {s_q.rx[14:0], s_q.mosi_b};
            if (s_q.cnt != 5'h1f) begin
                s_d.cnt = s_q.cnt + 5'h01;
            end
        end
        if (in_frame && sclk_fall) begin
            s_d.tx = {s_q.tx[14:0], 1'b0};
        end

        // short or long frames are dropped and load no new reply
        if (cs_rise && s_q.cnt == FRAME_BITS_5) begin
            unique case (s_q.mode)
                WAIT_ENTRY: begin
                    if (s_q.rx == ENTRY_CMD) begin
                        s_d.tx   = ~s_q.rx;
                        s_d.mode = DIAG;
                    end else begin
                        s_d.mode = LOCKED;
                        if (s_q.rx[15:14] == NEAR_TOP) begin
                            s_d.tx = {LOCK_TOP, s_q.rx[13:0]};
                        end else begin
                            s_d.tx = ZERO_RSP;
                        end
                    end
                end
                LOCKED: begin
                    s_d.tx = ZERO_RSP;
                end
                DIAG: begin
                    if (s_q.skip) begin
                        s_d.skip = 1'b0;
                        s_d.tx   = PFAULT_RSP;
                    end else if (op == OP_PTR_WR && s_q.rx[PAR_RD_POS]) begin
                        if (wr_par_ok) begin
                            s_d.ptr = s_q.rx[7:0];
                            s_d.tx  = hdr(RH_PTR, RL_PTR, 8'h00);
                        end else begin
                            s_d.skip = 1'b1;
                            s_d.tx   = PFAULT_RSP;
                        end
                    end else if (op == OP_PTR_RD && !s_q.rx[PAR_WR_POS]) begin
                        if (rd_par_ok) begin
                            s_d.tx = hdr(RH_PTR, RL_PTR, s_q.ptr);
                        end else begin
                            s_d.skip = 1'b1;
                            s_d.tx   = PFAULT_RSP;
                        end
                    end else if (op == OP_DAT_WR && !s_q.rx[PAR_RD_POS]) begin
                        if (wr_par_ok) begin
                            // update lands on the first cycle that sees select high
                            s_d.regs[s_q.ptr] = s_q.rx[7:0];
                            s_d.wr_pulse      = 1'b1;
                            s_d.wr_addr       = s_q.ptr;
                            s_d.wr_data       = s_q.rx[7:0];
                            s_d.tx            = hdr(RH_DAT, RL_DAT, s_q.ptr);
                        end else begin
                            s_d.skip = 1'b1;
                            s_d.tx   = PFAULT_RSP;
                        end
                    end else if (op == OP_DAT_RD && !s_q.rx[PAR_WR_POS]) begin
                        if (rd_par_ok) begin
                            s_d.tx = hdr(RH_DAT, RL_DAT, s_q.regs[s_q.ptr]);
                        end else begin
                            s_d.skip = 1'b1;
                            s_d.tx   = PFAULT_RSP;
                        end
                    end else if (op == OP_ACC_RD && s_q.rx[9:0] == 10'h000) begin
                        if (rd_par_ok) begin
                            s_d.tx = odd_reply({RH_ACC, 1'b0, accel_sample});
                        end else begin
                            s_d.skip = 1'b1;
                            s_d.tx   = PFAULT_RSP;
                        end
                    end else begin
                        // echo of the command with odd parity in bit 15
                        s_d.tx = {~(^s_q.rx[14:0]), s_q.rx[14:0]};
                    end
                end
                default: begin
                    s_d.mode = LOCKED;
                    s_d.tx   = ZERO_RSP;
                end
            endcase
        end
    end

    // =====================================================================
    // registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            // select flops start at the idle level, so no false edge follows reset
            s_q      <= '0;
            s_q.cs_a <= 1'b1;
            s_q.cs_b <= 1'b1;
            s_q.cs_c <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // =====================================================================
    // outputs
    assign link.miso      = s_q.tx[15];
    assign diag_prog_mode = (s_q.mode == DIAG);
    assign entry_locked   = (s_q.mode == LOCKED);
    assign reg_wr_pulse   = s_q.wr_pulse;
    assign reg_wr_addr    = s_q.wr_addr;
    assign reg_wr_data    = s_q.wr_data;

endmodule // spi_diag_dev

//--- hdl/spi_diag_host.sv
// master end of the diagnostic link: sends one 16-bit word per frame
`timescale 1ns/1ps
module spi_diag_host
    import spi_diag_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // link
    spi_diag_if.host         link,
    // command side
    input  wire logic        cmd_valid,
    input  wire logic [15:0] cmd_word,
    output logic             cmd_ready,
    // reply side: reply to the previous command
    output logic             rsp_valid,
    output logic [15:0]      rsp_word
);

    // =====================================================================
    // state
    typedef struct packed {
        hstate_t     st;
        logic [3:0]  div;
        logic [3:0]  bitn;
        logic [15:0] sh;
        logic [15:0] rx;
        logic        sclk;
        logic        cs_n;
        logic        mosi;
        logic        miso_a;
        logic        miso_b;
        logic        rsp_v;
        logic [15:0] rsp;
    } host_state_t;

    host_state_t s_q;
    host_state_t s_d;

    // =====================================================================
    // next state
    always_comb begin
        s_d        = s_q;
        s_d.rsp_v  = 1'b0;
        s_d.miso_a = link.miso;
        s_d.miso_b = s_q.miso_a;
        s_d.div    = s_q.div + 4'h1;
        unique case (s_q.st)
            H_IDLE: begin
                s_d.div = 4'h0;
                if (cmd_valid) begin
                    s_d.sh   = cmd_word;
                    s_d.mosi = cmd_word[15];
                    s_d.cs_n = 1'b0;
                    s_d.bitn = 4'h0;
                    s_d.st   = H_LOW;
                end
            end
            H_LOW: begin
                if (s_q.div == HALF_LAST) begin
                    s_d.div  = 4'h0;
                    s_d.sclk = 1'b1;
                    s_d.st   = H_HIGH;
                end
            end
            H_HIGH: begin
                if (s_q.div == HALF_LAST) begin
                    // sample late in the high phase: the sensor reacts through
                    // synchronisers, so its bit settles well after our edge
                    s_d.div  = 4'h0;
                    s_d.sclk = 1'b0;
                    s_d.rx   = {s_q.rx[14:0], s_q.miso_b};
                    if (s_q.bitn == LAST_BIT) begin
                        s_d.st = H_TRAIL;
                    end else begin
                        s_d.bitn = s_q.bitn + 4'h1;
                        s_d.sh   = {s_q.sh[14:0], 1'b0};
                        s_d.mosi = s_q.sh[14];
                        s_d.st   = H_LOW;
                    end
                end
            end
            H_TRAIL: begin
                if (s_q.div == HALF_LAST) begin
                    s_d.div  = 4'h0;
                    s_d.cs_n = 1'b1;
                    s_d.st   = H_GAP;
                end
            end
            H_GAP: begin
                // gap lets the sensor decode and load its next reply
                if (s_q.div == GAP_LAST) begin
                    s_d.rsp_v = 1'b1;
                    s_d.rsp   = s_q.rx;
                    s_d.st    = H_IDLE;
                end
            end
            default: begin
                s_d.st = H_IDLE;
            end
        endcase
    end

    // =====================================================================
    // registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q      <= '0;
            s_q.cs_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // =====================================================================
    // outputs
    assign link.sclk = s_q.sclk;
    assign link.cs_n = s_q.cs_n;
    assign link.mosi = s_q.mosi;
    assign cmd_ready = (s_q.st == H_IDLE);
    assign rsp_valid = s_q.rsp_v;
    assign rsp_word  = s_q.rsp;

endmodule // spi_diag_host

//--- hdl/spi_diag_if.sv
// serial link between the diagnostic master and the sensor end
`timescale 1ns/1ps
interface spi_diag_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;

    // =====================================================================
    // sensor end
    modport dev (
        input  sclk,
        input  cs_n,
        input  mosi,
        output miso
    );

    // =====================================================================
    // master end
    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input  miso
    );
endinterface

//--- hdl/spi_diag_pkg.sv
// shared constants and types for the diagnostic-mode serial link
package spi_diag_pkg;

    // =====================================================================
    // frame and command words
    localparam int          FRAME_BITS   = 16;
    localparam logic [4:0]  FRAME_BITS_5 = 5'h10;
    localparam logic [15:0] ENTRY_CMD    = 16'ha35c;
    localparam logic [15:0] PFAULT_RSP   = 16'h83ff;
    localparam logic [15:0] ZERO_RSP     = 16'h0000;

    // =====================================================================
    // opcode field, bits 15..11
    localparam int         OP_MSB      = 15;
    localparam int         OP_LSB      = 11;
    localparam int         PAR_RD_POS  = 10;
    localparam int         PAR_WR_POS  = 9;
    localparam int         RSP_PAR_POS = 10;
    localparam logic [4:0] OP_PTR_WR   = 5'h09;
    localparam logic [4:0] OP_PTR_RD   = 5'h08;
    localparam logic [4:0] OP_DAT_WR   = 5'h0b;
    localparam logic [4:0] OP_DAT_RD   = 5'h0a;
    localparam logic [4:0] OP_ACC_RD   = 5'h0c;

    // =====================================================================
    // response headers, bits 15..11, and bits 9..8
    localparam logic [4:0] RH_PTR  = 5'h16;
    localparam logic [4:0] RH_DAT  = 5'h14;
    localparam logic [4:0] RH_ACC  = 5'h13;
    localparam logic [1:0] RL_PTR  = 2'h1;
    localparam logic [1:0] RL_DAT  = 2'h2;
    localparam logic [1:0] LOCK_TOP = 2'h1;
    localparam logic [1:0] NEAR_TOP = 2'h2;

    // =====================================================================
    // timing: device clock and bench serial clock
    localparam int         CLK_NS       = 40;
    localparam int         SCLK_NS      = 320;
    localparam int         HALF_CYC     = (SCLK_NS / CLK_NS) / 2;
    localparam int         GAP_CYC      = 2 * HALF_CYC;
    localparam logic [3:0] HALF_LAST    = 4'(HALF_CYC - 1);
    localparam logic [3:0] GAP_LAST     = 4'(GAP_CYC - 1);
    localparam logic [3:0] LAST_BIT     = 4'hf;

    // =====================================================================
    // state encodings
    typedef enum logic [1:0] {WAIT_ENTRY, DIAG, LOCKED} mode_t;
    typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TRAIL, H_GAP} hstate_t;

endpackage

//--- testbench/spi_diag_command_decoder_bench.sv
// self-checking bench: host and sensor ends joined across the link
`timescale 1ns/1ps
module spi_diag_command_decoder_bench;
    import spi_diag_pkg::*;
    logic        clock        = 1'b0;
    logic        rst_n        = 1'b0;
    logic        cmd_valid    = 1'b0;
    logic [15:0] cmd_word     = 16'h0000;
    logic [9:0]  accel_sample = 10'h000;
    logic        cmd_ready, rsp_valid, diag_prog_mode, entry_locked, reg_wr_pulse;
    logic [15:0] rsp_word;
    logic [7:0]  reg_wr_addr, reg_wr_data;
    int          bad_count, checks, cycles, since_rise, pulses, exp_pulses;
    // bench model of the sensor end: mode 0 waiting, 1 diagnostic, 2 locked
    logic [1:0]  mode;
    logic        fault_q, wrote;
    logic [7:0]  ptr;
    logic [7:0]  regs [256];
    logic [15:0] exp_rsp, exp_wr;
    logic [2:0]  tops [4] = '{3'b001, 3'b011, 3'b110, 3'b101};

    always #20 clock = ~clock;
    spi_diag_if link ();
    spi_diag_host i_spi_diag_host (.clock(clock), .rst_n(rst_n), .link(link.host),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_word(rsp_word));
    spi_diag_dev i_spi_diag_dev (.clock(clock), .rst_n(rst_n), .link(link.dev),
        .accel_sample(accel_sample), .diag_prog_mode(diag_prog_mode),
        .entry_locked(entry_locked), .reg_wr_pulse(reg_wr_pulse),
        .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
    spi_diag_properties i_spi_diag_properties (.clock(clock), .rst_n(rst_n),
        .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // settled values are read on the falling edge
    always @(negedge clock) begin
        cycles++;
        since_rise = (link.cs_n === 1'b1) ? since_rise + 1 : 0;
        if (reg_wr_pulse === 1'b1) begin
            pulses++;
            check({15'h0000, since_rise > 0 && since_rise <= 5}, 16'h0001);
        end
        if (cycles > 40000) begin
            bad_count++;
            complete_run();
        end
    end

    function automatic logic [15:0] mk(input int k, input logic [15:0] r);
        logic [15:0] w;
        case (k)
            0: w = {OP_PTR_WR, 2'b10, r[8:0]};
            1: w = {OP_PTR_RD, 2'b00, r[8:0]};
            2: w = {OP_DAT_WR, 2'b00, r[8:0]};
            3: w = {OP_DAT_RD, 2'b00, r[8:0]};
            4: w = {OP_ACC_RD, 11'h000};
            default: return r;
        endcase
        if (k == 0 || k == 2) w[PAR_WR_POS] = ~^w;
        else w[PAR_RD_POS] = ~^w[15:11];
        return w;
    endfunction

    function automatic logic [15:0] predict(input logic [15:0] c);
        logic [15:0] r;
        logic [4:0]  op;
        logic        wr;
        op = c[15:11];
        wr = (op == OP_PTR_WR || op == OP_DAT_WR);
        wrote = 1'b0;
        if (mode == 2'd0) begin
            mode = (c == ENTRY_CMD) ? 2'd1 : 2'd2;
            if (c == ENTRY_CMD) return ~c;
            return (c[15:14] == 2'b10) ? {LOCK_TOP, c[13:0]} : ZERO_RSP;
        end
        if (mode == 2'd2) return ZERO_RSP;
        if (fault_q) begin
            fault_q = 1'b0;
            return PFAULT_RSP;
        end
        if (op == OP_PTR_WR && c[10]) r = {RH_PTR, 1'b0, RL_PTR, 8'h00};
        else if (op == OP_PTR_RD && !c[9]) r = {RH_PTR, 1'b0, RL_PTR, ptr};
        else if (op == OP_DAT_WR && !c[10]) r = {RH_DAT, 1'b0, RL_DAT, ptr};
        else if (op == OP_DAT_RD && !c[9]) r = {RH_DAT, 1'b0, RL_DAT, regs[ptr]};
        else if (op == OP_ACC_RD && c[9:0] == 10'h000) r = {RH_ACC, 1'b0, accel_sample};
        else return {~^c[14:0], c[14:0]};
        if (wr ? !(^c) : !(^c[15:10])) begin
            fault_q = 1'b1;
            return PFAULT_RSP;
        end
        if (op == OP_PTR_WR) ptr = c[7:0];
        if (op == OP_DAT_WR) begin
            regs[ptr] = c[7:0];
            exp_wr = {ptr, c[7:0]};
            wrote = 1'b1;
            exp_pulses++;
        end
        r[RSP_PAR_POS] = ~^r;
        return r;
    endfunction

    // one frame; the reply seen belongs to the previous command
    task automatic send(input logic [15:0] w);
        int n;
        n = 0;
        @(posedge clock);
        #1 cmd_valid = 1'b1;
        cmd_word = w;
        accel_sample = 10'($urandom);
        check({15'h0000, cmd_ready}, 16'h0001);
        @(posedge clock);
        #1 cmd_valid = 1'b0;
        check({15'h0000, cmd_ready}, 16'h0000);
        while (rsp_valid !== 1'b1 && n < 300) begin
            @(posedge clock);
            #1 n++;
        end
        // a hung frame runs into the limit and shows up here as a mismatch
        check(16'(n), 16'(HALF_CYC * (2 * FRAME_BITS + 1) + GAP_CYC));
        check(rsp_word, exp_rsp);
        exp_rsp = predict(w);
        if (wrote) check({reg_wr_addr, reg_wr_data}, exp_wr);
    endtask

    task automatic do_reset();
        @(posedge clock);
        #1 rst_n = 1'b0;
        repeat (10) @(posedge clock);
        #1 rst_n = 1'b1;
        check({14'h0000, diag_prog_mode, entry_locked}, 16'h0000);
        mode = 2'd0;
        fault_q = 1'b0;
        ptr = 8'h00;
        exp_rsp = ZERO_RSP;
        foreach (regs[i]) regs[i] = 8'h00;
    endtask

    initial begin
        logic [15:0] c;
        void'($urandom(32'h42cb));
        // wrong first commands, then the entry word which must stay refused
        for (int i = 0; i < 4; i++) begin
            do_reset();
            c = 16'($urandom);
            c[15:13] = tops[i];
            if (c == ENTRY_CMD) c[0] = ~c[0];
            send(c);
            send(ENTRY_CMD);
            send(mk(1, 16'h0000));
            check({14'h0000, diag_prog_mode, entry_locked}, 16'h0001);
        end
        do_reset();
        send(ENTRY_CMD);
        send(mk(0, 16'h00ff));
        check({15'h0000, diag_prog_mode}, 16'h0001);
        send(mk(2, 16'h005a));
        send(mk(3, 16'h0000));
        send(mk(0, 16'h0011) ^ 16'h0200);
        send(mk(0, 16'h0022));
        send(mk(1, 16'h0000));
        send(mk(4, 16'h0000));
        send(16'hffff);
        for (int i = 0; i < 120; i++) begin
            c = mk($urandom_range(0, 5), 16'($urandom));
            if ($urandom_range(0, 7) == 0) c[$urandom_range(0, 15)] ^= 1'b1;
            send(c);
        end
        // sixth reset mid-run: back to waiting, registers cleared
        do_reset();
        send(ENTRY_CMD);
        send(mk(3, 16'h0000));
        send(mk(1, 16'h0000));
        send(mk(4, 16'h0000));
        check(16'(pulses), 16'(exp_pulses));
        complete_run();
    end
endmodule // spi_diag_command_decoder_bench

//--- testbench/spi_diag_properties.sv
// wire-level properties of the diagnostic serial link
`timescale 1ns/1ps
module spi_diag_properties (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // link wires
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso
);
    // =====================================================================
    // rising serial edges seen in the current frame
    logic       sclk_q;
    logic [4:0] rises_q;
    always_ff @(posedge clock) begin
        sclk_q <= sclk;
        if (!rst_n || cs_n) begin
            rises_q <= 5'h00;
        end else if (sclk && !sclk_q) begin
            rises_q <= rises_q + 5'h01;
        end
    end

    // =====================================================================
    // phases of a frame
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence low_four;
        !sclk [*4];
    endsequence
    sequence high_four;
        sclk [*4];
    endsequence
    sequence select_tail;
        !cs_n [*4] ##1 cs_n;
    endsequence

    chk_idle_clock_low: assert property (cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    chk_high_phase: assert property ($rose(sclk) |-> high_four)
        else $error("serial clock high phase too short");
    chk_low_phase: assert property ($fell(sclk) && rises_q != 5'h10 |-> low_four ##1 sclk)
        else $error("serial clock low phase wrong");
    chk_frame_start: assert property ($fell(cs_n) |-> low_four ##1 sclk)
        else $error("first serial edge not four clocks after select");
    chk_frame_tail: assert property ($fell(sclk) && rises_q == 5'h10 |-> select_tail)
        else $error("select not released four clocks after last bit");
    chk_select_gap: assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("gap between frames too short");
    chk_bit_count: assert property ($rose(cs_n) |-> rises_q == 5'h10)
        else $error("frame without sixteen bits");
    chk_mosi_hold: assert property (sclk |-> $stable(mosi))
        else $error("command bit moved while clock high");
    chk_miso_hold: assert property (sclk && !cs_n |-> $stable(miso))
        else $error("reply bit moved while clock high");
endmodule // spi_diag_properties
